// ---- sim/tiu_pin_model.sv ----
// Far-side pin model: count pin pulse train and external request pins
module tiu_pin_model (
    input wire logic clk, // Machine clock
    input wire logic rst_n, // Async reset, low active
    input wire logic go, // Start a pulse train
    input wire logic [7:0] pulses, // Falling edges to make
    input wire logic ext0_level, // Level for ext0 pin
    input wire logic ext1_level, // Level for ext1 pin
    output logic count_pin, // Count pin, idles high
    output logic ext0_pin, // External request 0
    output logic ext1_pin, // External request 1
    output logic busy // Train in progress
);
    timeunit 1ns;
    timeprecision 100ps;
    // Two machine cycles per half, so a once-per-tick sampler sees both
    localparam int HALF = 24;
    logic [7:0] left_ff;
    logic [5:0] cyc_ff;

    assign ext0_pin = ext0_level;
    assign ext1_pin = ext1_level;
    assign busy = (left_ff != 8'h00);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_ff <= 8'h00;
            cyc_ff <= 6'h00;
            count_pin <= 1'b1;
        end
        else if (go && !busy)
        begin
            left_ff <= pulses;
            cyc_ff <= 6'h00;
        end
        else if (busy)
        begin
            if (cyc_ff == 6'(HALF - 1))
            begin
                cyc_ff <= 6'h00;
                count_pin <= ~count_pin;
                if (!count_pin)
                    left_ff <= left_ff - 8'h01;
            end
            else
                cyc_ff <= cyc_ff + 6'h01;
        end
    end
endmodule : tiu_pin_model

// ---- sim/tiu_top_test.sv ----
// Self-checking bench for the timer and interrupt unit
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("[ERR] %s exp %h got %h", nm, ex, got); \
        end \
    end
module tiu_top_test
    import tiu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ZOFS [7] = '{TIU_TIMER_CONTROL_OFS, TIU_IEN_OFS,
        TIU_CNTL_OFS, TIU_CNTH_OFS, TIU_RLDL_OFS, TIU_RLDH_OFS, TIU_FTCNT_OFS};
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, int_vector, pulses;
    logic [31:0] pwdata, prdata, rdata;
    logic irq, int_req, cnt_pin, e0_pin, e1_pin, e0_lvl, e1_lvl, go, busy;
    int errors, samples_checked, cyc, t0;

    tiu_top dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .COUNT_INPUT_PIN(cnt_pin), .EXT_IRQ0_PIN(e0_pin),
        .EXT_IRQ1_PIN(e1_pin), .IRQ(irq), .INT_REQ(int_req),
        .INT_VECTOR(int_vector));
    tiu_pin_model pins (.clk(mclk), .rst_n(rst_n), .go(go),
        .pulses(pulses), .ext0_level(e0_lvl), .ext1_level(e1_lvl),
        .count_pin(cnt_pin), .ext0_pin(e0_pin), .ext1_pin(e1_pin),
        .busy(busy));

    always #12.5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    task finish_test;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // No wait limit here; the watchdog ends a hung transfer
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rdata)
    endtask : rd

    task rdr(input logic [7:0] a, input int lo, input int hi);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("range %h", a), 1'b1, (rdata >= lo && rdata <= hi))
    endtask : rdr

    task wait_bit(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        while (rdata[b] !== 1'b1 && n < 6000);
        `CHK("wait bit", 1'b1, rdata[b])
    endtask : wait_bit

    // Pin causes need two sync edges plus the output register
    task req(input logic r, input logic [7:0] v);
        repeat (4) @(posedge mclk);
        `CHK("int_req", r, int_req)
        `CHK("int_vector", v, int_vector)
    endtask : req

    initial
    begin
        #1000000;
        errors++;
        finish_test();
    end

    initial
    begin
        mclk = 0;
        rst_n = 0;
        {psel, penable, pwrite, go} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pulses = 8'h00;
        {e0_lvl, e1_lvl} = 2'b11;
        {errors, samples_checked} = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (ZOFS[i]) rd(ZOFS[i], 32'h0);
        rd(8'h40, 32'h0);
        `CHK("slverr", 1'b1, err)
        wr(TIU_IEN_OFS, 32'hff);
        rd(TIU_IEN_OFS, 32'h8f);
        wr(TIU_IEN_OFS, 32'h0);
        wr(TIU_TIMER_CONTROL_OFS, 32'ha5);
        rd(TIU_TIMER_CONTROL_OFS, 32'ha5);
        // Overflow two steps after start, then stop before the next tick
        wr(TIU_RLDL_OFS, 32'h34);
        wr(TIU_RLDH_OFS, 32'h12);
        wr(TIU_CNTL_OFS, 32'hfe);
        wr(TIU_CNTH_OFS, 32'hff);
        wr(TIU_MASK_OFS, 32'h1);
        wr(TIU_IEN_OFS, 32'h82);
        wr(TIU_TIMER_CONTROL_OFS, 32'h10);
        wait_bit(TIU_STAT_OFS, TIU_EV_OVF);
        wr(TIU_TIMER_CONTROL_OFS, 32'h20);
        rd(TIU_CNTL_OFS, 32'h34);
        rd(TIU_CNTH_OFS, 32'h12);
        rd(TIU_RLDL_OFS, 32'h34);
        rd(TIU_RLDH_OFS, 32'h12);
        rd(TIU_TIMER_CONTROL_OFS, 32'h20);
        `CHK("irq", 1'b1, irq)
        req(1'b1, TIU_VEC_CT);
        wr(TIU_TAKE_OFS, 32'h0123);
        rd(TIU_SPC_OFS, 32'h0123);
        rd(TIU_TAKE_OFS, 32'h0b);
        rd(TIU_TIMER_CONTROL_OFS, 32'h00);
        req(1'b0, TIU_VEC_RST);
        wr(TIU_STAT_OFS, 32'hf);
        repeat (3) @(posedge mclk);
        `CHK("irq", 1'b0, irq)
        // Qualified counting holds while ext0 is low
        wr(TIU_IEN_OFS, 32'h0);
        wr(TIU_CNTL_OFS, 32'h0);
        wr(TIU_CNTH_OFS, 32'h0);
        e0_lvl <= 1'b0;
        wr(TIU_TIMER_CONTROL_OFS, 32'h90);
        repeat (60) @(posedge mclk);
        rd(TIU_CNTL_OFS, 32'h0);
        e0_lvl <= 1'b1;
        repeat (60) @(posedge mclk);
        wr(TIU_TIMER_CONTROL_OFS, 32'h0);
        rdr(TIU_CNTL_OFS, 4, 6);
        wr(TIU_CNTL_OFS, 32'h0);
        wr(TIU_TIMER_CONTROL_OFS, 32'h50);
        pulses <= 8'h03;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (200) @(posedge mclk);
        wr(TIU_TIMER_CONTROL_OFS, 32'h0);
        rd(TIU_CNTL_OFS, 32'h3);
        // Edge mode on both pins, then level mode
        wr(TIU_STAT_OFS, 32'hf);
        wr(TIU_TIMER_CONTROL_OFS, 32'h05);
        wr(TIU_IEN_OFS, 32'h87);
        e0_lvl <= 1'b0;
        e1_lvl <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(TIU_TIMER_CONTROL_OFS, 32'h0f);
        rd(TIU_STAT_OFS, 32'h6);
        req(1'b1, TIU_VEC_E0);
        wr(TIU_TAKE_OFS, 32'h0200);
        rd(TIU_TIMER_CONTROL_OFS, 32'h07);
        req(1'b1, TIU_VEC_E1);
        wr(TIU_TAKE_OFS, 32'h0300);
        rd(TIU_TIMER_CONTROL_OFS, 32'h05);
        wr(TIU_TIMER_CONTROL_OFS, 32'h0);
        req(1'b1, TIU_VEC_E0);
        rd(TIU_TIMER_CONTROL_OFS, 32'h0);
        e0_lvl <= 1'b1;
        req(1'b1, TIU_VEC_E1);
        wr(TIU_IEN_OFS, 32'h07);
        req(1'b0, TIU_VEC_RST);
        e1_lvl <= 1'b1;
        wr(TIU_IEN_OFS, 32'h0);
        wr(TIU_STAT_OFS, 32'hf);
        // Fixed-rate timer
        wr(TIU_FTCTL_OFS, 32'h10);
        repeat (120) @(posedge mclk);
        rdr(TIU_FTCNT_OFS, 9, 11);
        wr(TIU_FTCTL_OFS, 32'h0);
        rd(TIU_FTCNT_OFS, 32'h0);
        rd(TIU_FTCTL_OFS, 32'h0);
        wr(TIU_FTCTL_OFS, 32'h10);
        t0 = cyc;
        rd(TIU_FTCTL_OFS, 32'h10);
        wait_bit(TIU_STAT_OFS, TIU_EV_FT);
        t0 = cyc - t0;
        `CHK("ft span", 1'b1, (t0 >= 12270 && t0 <= 12300))
        rdr(TIU_FTCNT_OFS, 0, 0);
        wr(TIU_IEN_OFS, 32'h88);
        req(1'b1, TIU_VEC_FT);
        rd(TIU_VEC_OFS, 32'h11b);
        wr(TIU_IEN_OFS, 32'h80);
        req(1'b0, TIU_VEC_RST);
        wr(TIU_IEN_OFS, 32'h08);
        req(1'b0, TIU_VEC_RST);
        wr(TIU_IEN_OFS, 32'h88);
        wr(TIU_FTCTL_OFS, 32'h30);
        req(1'b0, TIU_VEC_RST);
        finish_test();
    end
endmodule : tiu_top_test

// ---- src/tiu_pkg.sv ----
// Shared constants for the timer and interrupt unit
package tiu_pkg;
    // APB byte addresses
    localparam logic [7:0] TIU_TIMER_CONTROL_OFS = 8'h00;
    localparam logic [7:0] TIU_IEN_OFS = 8'h04;
    localparam logic [7:0] TIU_CNTL_OFS = 8'h08;
    localparam logic [7:0] TIU_CNTH_OFS = 8'h0c;
    localparam logic [7:0] TIU_RLDL_OFS = 8'h10;
    localparam logic [7:0] TIU_RLDH_OFS = 8'h14;
    localparam logic [7:0] TIU_FTCTL_OFS = 8'h18;
    localparam logic [7:0] TIU_FTCNT_OFS = 8'h1c;
    localparam logic [7:0] TIU_STAT_OFS = 8'h20;
    localparam logic [7:0] TIU_MASK_OFS = 8'h24;
    localparam logic [7:0] TIU_TAKE_OFS = 8'h28;
    localparam logic [7:0] TIU_VEC_OFS = 8'h2c;
    localparam logic [7:0] TIU_SPC_OFS = 8'h30;
    // Timer control fields
    localparam int TIU_TC_QUAL = 7;
    localparam int TIU_TC_SRC = 6;
    localparam int TIU_TC_OVF = 5;
    localparam int TIU_TC_RUN = 4;
    localparam int TIU_TC_E0F = 3;
    localparam int TIU_TC_E0T = 2;
    localparam int TIU_TC_E1F = 1;
    localparam int TIU_TC_E1T = 0;
    // Interrupt enable fields
    localparam int TIU_IE_GLB = 7;
    localparam int TIU_IE_FT = 3;
    localparam int TIU_IE_EX1 = 2;
    localparam int TIU_IE_CT = 1;
    localparam int TIU_IE_EX0 = 0;
    // Fixed timer control fields
    localparam int TIU_FT_CLR = 5;
    localparam int TIU_FT_RUN = 4;
    // Event status bit positions
    localparam int TIU_EV_OVF = 0;
    localparam int TIU_EV_E0 = 1;
    localparam int TIU_EV_E1 = 2;
    localparam int TIU_EV_FT = 3;
    // Reset values
    localparam logic [7:0] TIU_TIMER_CONTROL_RST = 8'h00;
    localparam logic [7:0] TIU_IEN_RST = 8'h00;
    localparam logic [7:0] TIU_CNT_RST = 8'h00;
    localparam logic [7:0] TIU_RLD_RST = 8'h00;
    localparam logic [7:0] TIU_VEC_RST = 8'h00;
    // Vectors
    localparam logic [7:0] TIU_VEC_E0 = 8'h03;
    localparam logic [7:0] TIU_VEC_CT = 8'h0b;
    localparam logic [7:0] TIU_VEC_E1 = 8'h13;
    localparam logic [7:0] TIU_VEC_FT = 8'h1b;
    // Timing: one machine cycle is 12 oscillator periods
    localparam int TIU_MC_DIV = 12;
    localparam logic [3:0] TIU_MC_LAST = 4'(TIU_MC_DIV - 1);
    localparam logic [9:0] TIU_FT_LAST = 10'h3ff;
endpackage : tiu_pkg

// ---- src/tiu_top.sv ----
// Timer/counter, fixed-rate timer and fixed-priority interrupt unit
// Functional notes
// - Count machine ticks or count pin falls
// - Count only with run; qualify needs ext0 high
// - Sixteen-bit increment, reload on overflow, reload kept
// - Overflow sets flag, requests if enabled
// - Timer control bit order fixed, qualify first
// - Trigger type one: edge sets flag; zero: level
// - Fixed timer advances once per machine cycle
// - Run bit four enables; zero stops, clears
// - Ten-bit fixed timer carry sets its flag
// - Fixed timer irq needs bit three and global
// - Writing one to bit five clears flag
// - Fixed timer vector is 1b hex
// - Priority ext0, counter, ext1, fixed timer
// - Taking an interrupt saves only the PC
// - Global enable zero blocks every INT_REQ interrupt; IRQ is not gated
// - Enable bits three, two, one, zero; six-four reserved
//
// The APB register port and the placing of the registers were decided locally.
module tiu_top
    import tiu_pkg::*;
(
    input wire logic MCLK, // 40 MHz clock
    input wire logic RST_N, // Async reset
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // Unmapped address
    input wire logic COUNT_INPUT_PIN, // External count pin
    input wire logic EXT_IRQ0_PIN, // External interrupt 0, low active
    input wire logic EXT_IRQ1_PIN, // External interrupt 1, low active
    output logic IRQ, // Unmasked event status
    output logic INT_REQ, // Resolved request to core
    output logic [7:0] INT_VECTOR // Vector of pending request
);
    // Synchronisers
    logic cnt_s1_ff, cnt_s2_ff, e0_s1_ff, e0_s2_ff, e1_s1_ff, e1_s2_ff;
    logic cnt_smp_ff, e0_d_ff, e1_d_ff;
    logic [3:0] mc_cnt_ff;
    logic tick_ff;
    logic [7:0] timer_control_ff, ien_ff, cntl_ff, cnth_ff, rldl_ff, rldh_ff;
    logic ft_run_ff, ft_flag_ff;
    logic [9:0] ft_cnt_ff;
    logic [3:0] stat_ff, mask_ff;
    logic [15:0] spc_ff;
    logic [7:0] vec_taken_ff;
    logic [31:0] nxt_rdata;
    logic acc, wr, cnt_fall, adv, ovf, ft_adv, ft_carry;
    logic e0_fall, e1_fall, hit;
    logic req_e0, req_ct, req_e1, req_ft, req_any, take;
    logic [7:0] nxt_vec;
    logic [3:0] ev;

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cnt_s1_ff <= 1'b1;
            cnt_s2_ff <= 1'b1;
            e0_s1_ff <= 1'b1;
            e0_s2_ff <= 1'b1;
            e1_s1_ff <= 1'b1;
            e1_s2_ff <= 1'b1;
            e0_d_ff <= 1'b1;
            e1_d_ff <= 1'b1;
        end
        else
        begin
            cnt_s1_ff <= COUNT_INPUT_PIN;
            cnt_s2_ff <= cnt_s1_ff;
            e0_s1_ff <= EXT_IRQ0_PIN;
            e0_s2_ff <= e0_s1_ff;
            e1_s1_ff <= EXT_IRQ1_PIN;
            e1_s2_ff <= e1_s1_ff;
            e0_d_ff <= e0_s2_ff;
            e1_d_ff <= e1_s2_ff;
        end
    end

    // Machine cycle tick, one in twelve clocks
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mc_cnt_ff <= 4'h0;
            tick_ff <= 1'b0;
        end
        else
        begin
            mc_cnt_ff <= (mc_cnt_ff == TIU_MC_LAST) ? 4'h0 : mc_cnt_ff + 4'h1;
            tick_ff <= (mc_cnt_ff == TIU_MC_LAST);
        end
    end

    // Pin sampled once per machine cycle
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            cnt_smp_ff <= 1'b1;
        else if (tick_ff)
            cnt_smp_ff <= cnt_s2_ff;
    end

    assign acc = PSEL && PENABLE && PREADY;
    assign wr = acc && PWRITE;
    assign cnt_fall = tick_ff && cnt_smp_ff && !cnt_s2_ff;
    assign adv = timer_control_ff[TIU_TC_RUN]
        && (!timer_control_ff[TIU_TC_QUAL] || e0_s2_ff)
        && (timer_control_ff[TIU_TC_SRC] ? cnt_fall : tick_ff);
    assign ovf = adv && ({cnth_ff, cntl_ff} == 16'hffff);
    assign e0_fall = e0_d_ff && !e0_s2_ff;
    assign e1_fall = e1_d_ff && !e1_s2_ff;
    assign ft_adv = ft_run_ff && tick_ff;
    assign ft_carry = ft_adv && (ft_cnt_ff == TIU_FT_LAST);

    // Request resolution; level mode requests while the pin is low
    assign req_e0 = ien_ff[TIU_IE_EX0] && (timer_control_ff[TIU_TC_E0T] ?
        timer_control_ff[TIU_TC_E0F] : !e0_s2_ff);
    assign req_ct = ien_ff[TIU_IE_CT] && timer_control_ff[TIU_TC_OVF];
    assign req_e1 = ien_ff[TIU_IE_EX1] && (timer_control_ff[TIU_TC_E1T] ?
        timer_control_ff[TIU_TC_E1F] : !e1_s2_ff);
    assign req_ft = ien_ff[TIU_IE_FT] && ft_flag_ff;
    assign req_any = ien_ff[TIU_IE_GLB]
        && (req_e0 || req_ct || req_e1 || req_ft);

    always_comb
    begin
        if (req_e0)
            nxt_vec = TIU_VEC_E0;
        else if (req_ct)
            nxt_vec = TIU_VEC_CT;
        else if (req_e1)
            nxt_vec = TIU_VEC_E1;
        else if (req_ft)
            nxt_vec = TIU_VEC_FT;
        else
            nxt_vec = TIU_VEC_RST;
    end

    // Core takes the interrupt by writing its PC to the take register
    assign take = wr && (PADDR == TIU_TAKE_OFS) && req_any;

    // Timer control; hardware sets win over software and take clears
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            timer_control_ff <= TIU_TIMER_CONTROL_RST;
        else
        begin
            if (wr && PADDR == TIU_TIMER_CONTROL_OFS)
                timer_control_ff <= PWDATA[7:0];
            else if (take && nxt_vec == TIU_VEC_CT)
                timer_control_ff[TIU_TC_OVF] <= 1'b0;
            else if (take && nxt_vec == TIU_VEC_E0 && timer_control_ff[TIU_TC_E0T])
                timer_control_ff[TIU_TC_E0F] <= 1'b0;
            else if (take && nxt_vec == TIU_VEC_E1 && timer_control_ff[TIU_TC_E1T])
                timer_control_ff[TIU_TC_E1F] <= 1'b0;
            if (ovf)
                timer_control_ff[TIU_TC_OVF] <= 1'b1;
            if (e0_fall && timer_control_ff[TIU_TC_E0T])
                timer_control_ff[TIU_TC_E0F] <= 1'b1;
            if (e1_fall && timer_control_ff[TIU_TC_E1T])
                timer_control_ff[TIU_TC_E1F] <= 1'b1;
        end
    end

    // Count pair and reload; software write beats a count step
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cntl_ff <= TIU_CNT_RST;
            cnth_ff <= TIU_CNT_RST;
        end
        else if (wr && PADDR == TIU_CNTL_OFS)
            cntl_ff <= PWDATA[7:0];
        else if (wr && PADDR == TIU_CNTH_OFS)
            cnth_ff <= PWDATA[7:0];
        else if (ovf)
            {cnth_ff, cntl_ff} <= {rldh_ff, rldl_ff};
        else if (adv)
            {cnth_ff, cntl_ff} <= {cnth_ff, cntl_ff} + 16'h0001;
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rldl_ff <= TIU_RLD_RST;
            rldh_ff <= TIU_RLD_RST;
        end
        else if (wr && PADDR == TIU_RLDL_OFS)
            rldl_ff <= PWDATA[7:0];
        else if (wr && PADDR == TIU_RLDH_OFS)
            rldh_ff <= PWDATA[7:0];
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            ien_ff <= TIU_IEN_RST;
        else if (wr && PADDR == TIU_IEN_OFS)
            ien_ff <= PWDATA[7:0] & 8'h8f;
    end

    // Fixed-rate timer
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ft_run_ff <= 1'b0;
            ft_cnt_ff <= 10'h000;
        end
        else if (wr && PADDR == TIU_FTCTL_OFS && !PWDATA[TIU_FT_RUN])
        begin
            ft_run_ff <= 1'b0;
            ft_cnt_ff <= 10'h000;
        end
        else
        begin
            if (wr && PADDR == TIU_FTCTL_OFS)
                ft_run_ff <= 1'b1;
            if (ft_adv)
                ft_cnt_ff <= ft_cnt_ff + 10'h001;
        end
    end

    // A carry in the clearing cycle keeps the flag set
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            ft_flag_ff <= 1'b0;
        else if (ft_carry)
            ft_flag_ff <= 1'b1;
        else if (wr && PADDR == TIU_FTCTL_OFS && PWDATA[TIU_FT_CLR])
            ft_flag_ff <= 1'b0;
    end

    // Sticky event status, write one to clear, set wins
    assign ev = {ft_carry, e1_fall, e0_fall, ovf};
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            stat_ff <= 4'h0;
            mask_ff <= 4'h0;
        end
        else
        begin
            if (wr && PADDR == TIU_STAT_OFS)
                stat_ff <= (stat_ff & ~PWDATA[3:0]) | ev;
            else
                stat_ff <= stat_ff | ev;
            if (wr && PADDR == TIU_MASK_OFS)
                mask_ff <= PWDATA[3:0];
        end
    end

    // Only the interrupted PC is kept; the service routine saves the rest
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            spc_ff <= 16'h0000;
            vec_taken_ff <= TIU_VEC_RST;
        end
        else if (take)
        begin
            spc_ff <= PWDATA[15:0];
            vec_taken_ff <= nxt_vec;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            IRQ <= 1'b0;
            INT_REQ <= 1'b0;
            INT_VECTOR <= TIU_VEC_RST;
        end
        else
        begin
            IRQ <= |(stat_ff & mask_ff);
            INT_REQ <= req_any;
            INT_VECTOR <= req_any ? nxt_vec : TIU_VEC_RST;
        end
    end

    // APB: ready in the first access cycle, so no wait states
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        hit = 1'b1;
        case (PADDR)
            TIU_TIMER_CONTROL_OFS: nxt_rdata[7:0] = timer_control_ff;
            TIU_IEN_OFS: nxt_rdata[7:0] = ien_ff;
            TIU_CNTL_OFS: nxt_rdata[7:0] = cntl_ff;
            TIU_CNTH_OFS: nxt_rdata[7:0] = cnth_ff;
            TIU_RLDL_OFS: nxt_rdata[7:0] = rldl_ff;
            TIU_RLDH_OFS: nxt_rdata[7:0] = rldh_ff;
            TIU_FTCTL_OFS: nxt_rdata[TIU_FT_RUN] = ft_run_ff;
            TIU_FTCNT_OFS: nxt_rdata[9:0] = ft_cnt_ff;
            TIU_STAT_OFS: nxt_rdata[3:0] = stat_ff;
            TIU_MASK_OFS: nxt_rdata[3:0] = mask_ff;
            TIU_TAKE_OFS: nxt_rdata[7:0] = vec_taken_ff;
            TIU_VEC_OFS: nxt_rdata[8:0] = {req_any, nxt_vec};
            TIU_SPC_OFS: nxt_rdata[15:0] = spc_ff;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end
        else
        begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !hit;
            PRDATA <= (PSEL && !PENABLE && !PWRITE) ? nxt_rdata : 32'h0;
        end
    end

    // Checks
    sequence ft_write_s(int b, logic v);
        wr && PADDR == TIU_FTCTL_OFS && PWDATA[b] == v;
    endsequence

    sequence count_step_s;
        adv && !ovf && !(wr && (PADDR == TIU_CNTL_OFS
            || PADDR == TIU_CNTH_OFS));
    endsequence

    tick_period_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        tick_ff |-> ##12 tick_ff)
        else $error("machine tick not every 12 clocks");

    count_inc_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        count_step_s |=> {cnth_ff, cntl_ff} ==
            $past({cnth_ff, cntl_ff}) + 16'h0001)
        else $error("count pair did not step by one");

    reload_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        ovf && !wr |=> {cnth_ff, cntl_ff} == {rldh_ff, rldl_ff}
            && timer_control_ff[TIU_TC_OVF])
        else $error("overflow did not reload and flag");

    gate_hold_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        (!timer_control_ff[TIU_TC_RUN] || (timer_control_ff[TIU_TC_QUAL] && !e0_s2_ff))
            && !wr |=> $stable({cnth_ff, cntl_ff}))
        else $error("count moved while stopped or gated");

    ft_stop_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        ft_write_s(TIU_FT_RUN, 1'b0) |=> ft_cnt_ff == 10'h000
            && !ft_run_ff ##1 ft_cnt_ff == 10'h000)
        else $error("fixed timer not stopped and cleared");

    ft_carry_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        ft_carry |=> ft_flag_ff && ft_cnt_ff == 10'h000)
        else $error("fixed timer carry did not set flag");

    ft_clear_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        ft_write_s(TIU_FT_CLR, 1'b1) && !ft_carry |=> !ft_flag_ff)
        else $error("fixed timer flag not cleared");

    global_off_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        !ien_ff[TIU_IE_GLB] |=> !INT_REQ)
        else $error("request raised with global enable off");

    prio_vec_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        ien_ff[TIU_IE_GLB] && req_e0 |=> INT_VECTOR == TIU_VEC_E0)
        else $error("ext0 did not win priority");

    ft_vec_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        ien_ff[TIU_IE_GLB] && req_ft && !req_e0 && !req_ct && !req_e1
            |=> INT_VECTOR == TIU_VEC_FT)
        else $error("fixed timer vector wrong");

    take_clear_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        take && nxt_vec == TIU_VEC_CT && !ovf |=> !timer_control_ff[TIU_TC_OVF]
            && vec_taken_ff == TIU_VEC_CT)
        else $error("taking counter vector left flag set");
endmodule : tiu_top
